// file: hdl/ceau_pkg.sv
// Package of constants and types for the effective address unit
package ceau_pkg;
  // Prebyte codes
  localparam logic [7:0] PRE_Y_SELECT = 8'h90;
  localparam logic [7:0] PRE_IND_Y = 8'h91;
  localparam logic [7:0] PRE_IND_SELECT = 8'h92;
  // Reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] ZERO_PAGE_HI = 8'h00;
  // Base addressing modes as presented with the opcode
  typedef enum logic [3:0] {
    CEAU_INH = 4'h0,
    CEAU_IMM = 4'h1,
    CEAU_DIR_S = 4'h2,
    CEAU_DIR_L = 4'h3,
    CEAU_IDX_0 = 4'h4,
    CEAU_IDX_S = 4'h5,
    CEAU_IDX_L = 4'h6,
    CEAU_REL = 4'h7,
    CEAU_BIT_DIR = 4'h8,
    CEAU_BIT_REL = 4'h9
  } ceau_mode_t;
  // Sequencer states
  typedef enum logic [2:0] {
    CEAU_IDLE = 3'h0,
    CEAU_OPND_HI = 3'h1,
    CEAU_OPND_LO = 3'h2,
    CEAU_PTR_HI = 3'h3,
    CEAU_PTR_LO = 3'h4,
    CEAU_DONE = 3'h5
  } ceau_state_t;
endpackage : ceau_pkg

// file: hdl/ceau_adder.sv
// Unsigned index adder and signed relative adder for the address unit
`timescale 1ns/1ps
`default_nettype none
module ceau_adder (
  input wire logic [15:0] base,
  input wire logic [7:0] index,
  input wire logic use_index,
  input wire logic [15:0] pc,
  input wire logic [7:0] rel_off,
  output logic [15:0] idx_sum,
  output logic [15:0] rel_sum
);
  // Index sum is unsigned; a byte base plus byte index reaches 1FE
  assign idx_sum = base + (use_index ? {8'h00, index} : 16'h0000);
  // Relative offset is sign extended before adding to the PC
  assign rel_sum = pc + {{8{rel_off[7]}}, rel_off};
endmodule : ceau_adder
`default_nettype wire

// file: hdl/ceau_unit.sv
// Effective address sequencer: decodes modes and fetches operand bytes
//
// Summary of operation
// - Inherent opcodes fetch no operand bytes unless an indirect prebyte is given; then they fetch one byte.
// - Immediate fetches one byte and returns it as the operand value.
// - Short direct fetches one address byte; upper address byte is zero.
// - Long direct fetches a two-byte address anywhere in 64 Kbyte.
// - Indexed address is unsigned sum of X or Y and the offset.
// - Indexed without offset fetches nothing; uses index alone in page zero.
// - Short indexed adds one offset byte to index, reaching up to 1FE.
// - Long indexed adds the index to a two-byte offset.
// - Indirect modes read a pointer in memory, then use it as address.
// - One byte gives pointer location in page zero; byte or word pointer.
// - Short indirect result stays in page zero.
// - Indirect indexed adds X or Y to the pointer value, unsigned.
// - Short variants reach up to 1FE; long variants the full space.
// - Read-modify-write instructions accept only short addressing variants.
// - Relative target is PC plus signed 8-bit offset, direct or from memory.
// - Y-select prebyte swaps X for Y in immediate, direct, indexed, inherent.
// - Indirect-select prebyte turns direct forms and X-indexed into indirect.
// - Indirect-Y prebyte turns X indirect indexed into Y indirect indexed.
`timescale 1ns/1ps
`default_nettype none
module ceau_unit (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic START,
  input wire logic [7:0] PREBYTE,
  input wire logic PREBYTE_VALID,
  input wire logic [3:0] MODE,
  input wire logic RMW,
  input wire logic [7:0] X_REG,
  input wire logic [7:0] Y_REG,
  input wire logic [15:0] PC,
  output logic BUSY,
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD,
  input wire logic [7:0] MEM_DATA,
  output logic DONE,
  output logic [15:0] EA,
  output logic [7:0] IMM_VALUE,
  output logic IS_IMM,
  output logic IS_INH,
  output logic USE_Y,
  output logic ILLEGAL,
  output logic [1:0] OPND_LEN
);
  // ==========================================================
  // Decode
  // Registers captured at START and filled by the byte fetches
  ceau_pkg::ceau_state_t state_ff, nxt_state;
  ceau_pkg::ceau_mode_t mode_ff;
  logic ind_ff, use_y_ff, long_ff, idx_ff, rel_ff, ill_ff;
  logic [15:0] pc_ff, fetch_ff, ea_ff;
  logic [7:0] hi_ff, imm_ff, index_ff;
  logic done_ff, imm_flag_ff, inh_flag_ff;
  logic [1:0] len_ff;
  logic [15:0] idx_sum, rel_sum, adder_base;
  logic [7:0] rel_off;

  // Operand bytes after the opcode; indirect forms carry one pointer-location byte
  function automatic logic [1:0] opnd_bytes(input ceau_pkg::ceau_mode_t m, input logic ind);
    if (ind) begin
      opnd_bytes = 2'h1;
    end else begin
      case (m)
        ceau_pkg::CEAU_INH, ceau_pkg::CEAU_IDX_0: opnd_bytes = 2'h0;
        ceau_pkg::CEAU_DIR_L, ceau_pkg::CEAU_IDX_L: opnd_bytes = 2'h2;
        // Bit address plus branch offset; only the bit address is decoded here
        ceau_pkg::CEAU_BIT_REL: opnd_bytes = 2'h2;
        default: opnd_bytes = 2'h1;
      endcase
    end
  endfunction : opnd_bytes

  // Address of the second byte of a word; wraps at the top of the space
  function automatic logic [15:0] next_addr(input logic [15:0] a);
    next_addr = a + 16'h0001;
  endfunction : next_addr

  // Word from two fetched bytes; a byte-wide value lands in page zero
  function automatic logic [15:0] join_bytes(input logic word, input logic [7:0] hi,
      input logic [7:0] lo);
    join_bytes = word ? {hi, lo} : {ceau_pkg::ZERO_PAGE_HI, lo};
  endfunction : join_bytes

  // Long form test; shared by decode and the read-modify-write check
  function automatic logic is_long(input ceau_pkg::ceau_mode_t m);
    is_long = (m == ceau_pkg::CEAU_DIR_L) || (m == ceau_pkg::CEAU_IDX_L);
  endfunction : is_long

  ceau_pkg::ceau_mode_t mode_in;
  logic pre_y, pre_ind, pre_iy, pre_any_ind;
  assign mode_in = ceau_pkg::ceau_mode_t'(MODE);
  assign pre_y = PREBYTE_VALID && (PREBYTE == ceau_pkg::PRE_Y_SELECT);
  assign pre_ind = PREBYTE_VALID && (PREBYTE == ceau_pkg::PRE_IND_SELECT);
  assign pre_iy = PREBYTE_VALID && (PREBYTE == ceau_pkg::PRE_IND_Y);
  // Either indirect prebyte sends all but inherent and immediate modes through a pointer read
  assign pre_any_ind = pre_ind || pre_iy;

  // ==========================================================
  // Shared adder
  // No-offset indexed adds nothing; its indirect form adds the pointer instead
  assign adder_base = (mode_ff == ceau_pkg::CEAU_IDX_0 && !ind_ff) ? 16'h0000 : fetch_ff;
  assign rel_off = fetch_ff[7:0];
  ceau_adder u_adder (
    .base(adder_base),
    .index(index_ff),
    .use_index(idx_ff),
    .pc(pc_ff),
    .rel_off(rel_off),
    .idx_sum(idx_sum),
    .rel_sum(rel_sum)
  );

  // ==========================================================
  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ceau_pkg::CEAU_IDLE: begin
        // A START while busy never reaches here; the caller waits for BUSY low
        if (START) begin
          // inherent and no-offset indexed without an indirect prebyte go straight to done
          if (opnd_bytes(mode_in, pre_any_ind) == 2'h0)
            nxt_state = ceau_pkg::CEAU_DONE;
          // long direct and long indexed operands start at the high byte
          else if (is_long(mode_in) && !pre_any_ind)
            nxt_state = ceau_pkg::CEAU_OPND_HI;
          else
            nxt_state = ceau_pkg::CEAU_OPND_LO;
        end
      end
      ceau_pkg::CEAU_OPND_HI: nxt_state = ceau_pkg::CEAU_OPND_LO;
      ceau_pkg::CEAU_OPND_LO: begin
        // indirect modes go on to read the pointer
        if (ind_ff)
          nxt_state = long_ff ? ceau_pkg::CEAU_PTR_HI : ceau_pkg::CEAU_PTR_LO;
        else
          nxt_state = ceau_pkg::CEAU_DONE;
      end
      ceau_pkg::CEAU_PTR_HI: nxt_state = ceau_pkg::CEAU_PTR_LO;
      ceau_pkg::CEAU_PTR_LO: nxt_state = ceau_pkg::CEAU_DONE;
      ceau_pkg::CEAU_DONE: nxt_state = ceau_pkg::CEAU_IDLE;
      default: nxt_state = ceau_pkg::CEAU_IDLE;
    endcase
  end

  // State register
  // A low enable parks it mid-fetch; the memory must keep its byte meanwhile
  always_ff @(posedge MCLK) begin
    if (!RST_B)
      state_ff <= ceau_pkg::CEAU_IDLE;
    else if (CE)
      state_ff <= nxt_state;
  end

  // ==========================================================
  // Capture of mode, prebyte effects, index and PC at start
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      mode_ff <= ceau_pkg::CEAU_INH;
      ind_ff <= 1'b0;
      use_y_ff <= 1'b0;
      long_ff <= 1'b0;
      idx_ff <= 1'b0;
      rel_ff <= 1'b0;
      ill_ff <= 1'b0;
      index_ff <= ceau_pkg::BYTE_RST;
      pc_ff <= ceau_pkg::ADDR_RST;
      len_ff <= 2'h0;
    end else if (CE && state_ff == ceau_pkg::CEAU_IDLE && START) begin
      mode_ff <= mode_in;
      // direct, bit and relative forms become indirect; long stays word pointer
      ind_ff <= pre_any_ind && (mode_in != ceau_pkg::CEAU_INH)
                && (mode_in != ceau_pkg::CEAU_IMM);
      long_ff <= is_long(mode_in);
      // indexed modes select an index register
      idx_ff <= (mode_in == ceau_pkg::CEAU_IDX_0) || (mode_in == ceau_pkg::CEAU_IDX_S)
                || (mode_in == ceau_pkg::CEAU_IDX_L);
      rel_ff <= (mode_in == ceau_pkg::CEAU_REL);
      // Y prebyte or indirect-Y prebyte picks the Y register
      use_y_ff <= pre_y || pre_iy;
      // Index sampled here, so later changes to X or Y cannot move the address
      index_ff <= (pre_y || pre_iy) ? Y_REG : X_REG;
      pc_ff <= PC;
      // Flagged rather than blocked, so the core decides how to trap it
      // read-modify-write allows short forms only
      ill_ff <= RMW && is_long(mode_in);
      // indirect forms carry a single pointer-location byte
      len_ff <= opnd_bytes(mode_in, pre_any_ind);
    end
  end

  // ==========================================================
  // Byte fetches; fetch_ff holds address, offset or pointer
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      fetch_ff <= ceau_pkg::ADDR_RST;
      hi_ff <= ceau_pkg::BYTE_RST;
      imm_ff <= ceau_pkg::BYTE_RST;
    end else if (CE) begin
      case (state_ff)
        // Cleared on idle so a no-offset index never adds a stale value
        ceau_pkg::CEAU_IDLE: fetch_ff <= ceau_pkg::ADDR_RST;
        // first byte is the high-order byte
        ceau_pkg::CEAU_OPND_HI: hi_ff <= MEM_DATA;
        ceau_pkg::CEAU_OPND_LO: begin
          // short forms keep upper byte zero
          fetch_ff <= join_bytes(long_ff && !ind_ff, hi_ff, MEM_DATA);
          // immediate byte is the value itself
          imm_ff <= MEM_DATA;
        end
        ceau_pkg::CEAU_PTR_HI: hi_ff <= MEM_DATA;
        ceau_pkg::CEAU_PTR_LO: begin
          // byte pointer lands in page zero
          fetch_ff <= join_bytes(long_ff, hi_ff, MEM_DATA);
        end
        default: fetch_ff <= fetch_ff;
      endcase
    end
  end

  // ==========================================================
  // Memory address for each fetch; operand bytes follow the opcode
  // Reads only in fetch states; the bus is free in every other cycle
  always_comb begin
    MEM_RD = 1'b0;
    MEM_ADDR = ceau_pkg::ADDR_RST;
    case (state_ff)
      ceau_pkg::CEAU_OPND_HI: begin
        MEM_RD = 1'b1;
        MEM_ADDR = pc_ff;
      end
      ceau_pkg::CEAU_OPND_LO: begin
        MEM_RD = 1'b1;
        MEM_ADDR = (long_ff && !ind_ff) ? next_addr(pc_ff) : pc_ff;
      end
      // pointer sits in page zero at the fetched location
      ceau_pkg::CEAU_PTR_HI: begin
        MEM_RD = 1'b1;
        MEM_ADDR = fetch_ff;
      end
      ceau_pkg::CEAU_PTR_LO: begin
        MEM_RD = 1'b1;
        MEM_ADDR = long_ff ? next_addr(fetch_ff) : fetch_ff;
      end
      default: begin
        MEM_RD = 1'b0;
        MEM_ADDR = ceau_pkg::ADDR_RST;
      end
    endcase
  end

  // ==========================================================
  // Result registers; EA and the flags stand until the next request, DONE pulses for one cycle
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      ea_ff <= ceau_pkg::ADDR_RST;
      done_ff <= 1'b0;
      imm_flag_ff <= 1'b0;
      inh_flag_ff <= 1'b0;
    end else if (CE) begin
      done_ff <= (state_ff == ceau_pkg::CEAU_DONE);
      if (state_ff == ceau_pkg::CEAU_DONE) begin
        imm_flag_ff <= (mode_ff == ceau_pkg::CEAU_IMM);
        inh_flag_ff <= (mode_ff == ceau_pkg::CEAU_INH);
        // Relative wins; no relative opcode selects an index register
        // relative target from direct or memory-held offset
        if (rel_ff)
          ea_ff <= rel_sum;
        // index added unsigned to offset or pointer
        else if (idx_ff)
          ea_ff <= idx_sum;
        // short forms stay in page zero through zero upper byte
        else
          ea_ff <= fetch_ff;
      end
    end
  end

  // ==========================================================
  // Outputs; BUSY decodes the state, results and other flags come straight from flip-flops
  assign BUSY = (state_ff != ceau_pkg::CEAU_IDLE);
  assign DONE = done_ff;
  assign EA = ea_ff;
  assign IMM_VALUE = imm_ff;
  assign IS_IMM = imm_flag_ff;
  assign IS_INH = inh_flag_ff;
  assign USE_Y = use_y_ff;
  assign ILLEGAL = ill_ff;
  assign OPND_LEN = len_ff;
endmodule : ceau_unit
`default_nettype wire

// file: verification/ceau_mem_model.sv
// Behavioural program and data memory on the CPU read bus
`timescale 1ns/1ps
`default_nettype none
module ceau_mem_model (
  input wire logic MCLK,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  output logic [7:0] MEM_DATA
);
  // ====
  // Idle bus shows the inverse of the last byte, so stale data never passes
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff = 8'h00;
  always @(posedge MCLK) if (MEM_RD) last_ff <= mem[MEM_ADDR];
  assign MEM_DATA = MEM_RD ? mem[MEM_ADDR] : ~last_ff;
endmodule : ceau_mem_model
`default_nettype wire

// file: verification/ceau_unit_assertions.sv
// Port assertions for the effective address unit
`timescale 1ns/1ps
`default_nettype none
module ceau_unit_assertions (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic START,
  input wire logic [7:0] PREBYTE,
  input wire logic PREBYTE_VALID,
  input wire logic [3:0] MODE,
  input wire logic RMW,
  input wire logic [7:0] X_REG,
  input wire logic [15:0] PC,
  input wire logic BUSY,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic [7:0] MEM_DATA,
  input wire logic DONE,
  input wire logic [15:0] EA,
  input wire logic ILLEGAL
);
  // ====
  // Accepted request; plain means no prebyte in force
  wire take = CE && START && !BUSY;
  wire plain = take && !PREBYTE_VALID;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  chk_inh_no_fetch:
    assert property (plain && MODE == 4'h0 |=> !MEM_RD ##1 DONE && !MEM_RD) else $error("inh");
  chk_imm_one_byte:
    assert property (take && MODE == 4'h1 |=> MEM_RD && MEM_ADDR == $past(PC) ##1 !MEM_RD
      ##1 DONE) else $error("imm fetch");
  chk_dir_page_zero:
    assert property (plain && MODE == 4'h2 |-> ##3 DONE && EA[15:8] == 8'h00) else $error("dir");
  chk_long_dir_order:
    assert property (plain && MODE == 4'h3 |=> MEM_ADDR == $past(PC) ##1 MEM_RD
      && MEM_ADDR == $past(PC, 2) + 16'h0001 ##2 DONE) else $error("long dir");
  chk_idx_zero_ea:
    assert property (plain && MODE == 4'h4 |-> ##2 DONE && EA == {8'h00, $past(X_REG, 2)})
      else $error("idx none");
  chk_idx_short_sum:
    assert property (plain && MODE == 4'h5 |=> MEM_RD ##2 DONE
      && EA == {8'h00, $past(X_REG, 3)} + {8'h00, $past(MEM_DATA, 2)}) else $error("idx");
  chk_ind_ptr_page:
    assert property (take && PREBYTE_VALID && PREBYTE == ceau_pkg::PRE_IND_SELECT && MODE == 4'h2
      |=> MEM_ADDR == $past(PC) ##1 MEM_RD && MEM_ADDR[15:8] == 8'h00
      ##2 DONE && EA[15:8] == 8'h00) else $error("ind");
  chk_rmw_long:
    assert property (take |=> ILLEGAL == ($past(RMW) && ($past(MODE) == 4'h3
      || $past(MODE) == 4'h6))) else $error("rmw");
  // Main scenarios reached
  cov_rmw: cover property (take && RMW);
  cov_prebyte: cover property (take && PREBYTE_VALID);
  cov_rel: cover property (plain && MODE == 4'h7);
  cov_freeze: cover property (BUSY && !CE);
endmodule : ceau_unit_assertions
bind ceau_unit ceau_unit_assertions u_ceau_unit_assertions (.MCLK(MCLK), .RST_B(RST_B),
  .CE(CE), .START(START), .PREBYTE(PREBYTE), .PREBYTE_VALID(PREBYTE_VALID), .MODE(MODE),
  .RMW(RMW), .X_REG(X_REG), .PC(PC), .BUSY(BUSY), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
  .MEM_DATA(MEM_DATA), .DONE(DONE), .EA(EA), .ILLEGAL(ILLEGAL));
`default_nettype wire

// file: verification/ceau_unit_test.sv
// Self-checking bench for the effective address unit
`timescale 1ns/1ps
`default_nettype none
module ceau_unit_test;
  logic mclk = 1'b0, rst_b = 1'b0, start = 1'b0, pv = 1'b0, rmw = 1'b0, ce = 1'b1;
  logic [7:0] pre = 8'h00, xr = 8'h00, yr = 8'h00;
  logic [3:0] mode = 4'h0;
  logic [15:0] pc = 16'h0000;
  logic busy, mem_rd, done, is_imm, is_inh, use_y, illegal;
  logic [7:0] mem_data, imm;
  logic [15:0] mem_addr, ea;
  logic [1:0] len;
  int n_errors = 0, n_compared = 0;
  // ====
  // Clock, the unit and its memory
  always #50 mclk = ~mclk;
  ceau_unit u_ceau_unit (.MCLK(mclk), .RST_B(rst_b), .CE(ce), .START(start), .PREBYTE(pre),
    .PREBYTE_VALID(pv), .MODE(mode), .RMW(rmw), .X_REG(xr), .Y_REG(yr), .PC(pc), .BUSY(busy),
    .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_DATA(mem_data), .DONE(done), .EA(ea),
    .IMM_VALUE(imm), .IS_IMM(is_imm), .IS_INH(is_inh), .USE_Y(use_y), .ILLEGAL(illegal),
    .OPND_LEN(len));
  ceau_mem_model u_ceau_mem_model (.MCLK(mclk), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
    .MEM_DATA(mem_data));
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) n_errors++;
    if (seen !== exp) $display("mismatch %s expected %h seen %h", nm, exp, seen);
  endtask : chk
  // Two bytes, high first at the lower address
  task automatic wr2(input logic [15:0] a, input logic [15:0] w);
    u_ceau_mem_model.mem[a] = w[15:8];
    u_ceau_mem_model.mem[a + 16'h0001] = w[7:0];
  endtask : wr2
  // One request with operand bytes at the PC; bounded wait for the done pulse
  task automatic op(input logic [7:0] p, input logic [3:0] m, input logic r, input logic [7:0] x,
      input logic [7:0] y, input logic [15:0] a, input logic [15:0] w);
    int n;
    wr2(a, w);
    @(posedge mclk) #1;
    {pre, pv, mode, rmw, xr, yr, pc, start} = {p, p != 8'h00, m, r, x, y, a, 1'b1};
    @(posedge mclk) #1;
    start = 1'b0;
    chk("busy", 16'(busy), 16'h0001);
    for (n = 0; n < 20 && done !== 1'b1; n++) @(posedge mclk) #1;
    chk("wait", 16'(n < 20), 16'h0001);
    chk("idle", 16'(busy), 16'h0000);
  endtask : op
  // Inherent, immediate, short and long direct
  task automatic t_direct();
    op(8'h00, 4'h0, 1'b0, 8'h11, 8'h22, 16'h0300, 16'h0000);
    chk("inh", 16'(is_inh), 16'h0001);
    chk("len", 16'(len), 16'h0000);
    op(8'h00, 4'h1, 1'b0, 8'h11, 8'h22, 16'h0400, 16'hA500);
    chk("imm", 16'(imm), 16'h00A5);
    chk("is_imm", 16'(is_imm), 16'h0001);
    chk("len", 16'(len), 16'h0001);
    op(8'h00, 4'h2, 1'b0, 8'h11, 8'h22, 16'h0500, 16'h3400);
    chk("ea", ea, 16'h0034);
    op(8'h00, 4'h3, 1'b0, 8'h11, 8'h22, 16'h0600, 16'h1234);
    chk("ea", ea, 16'h1234);
    chk("len", 16'(len), 16'h0002);
    $display("t_direct done");
  endtask : t_direct
  // Index boundaries, Y select, read-modify-write on a long form
  task automatic t_indexed();
    op(8'h00, 4'h4, 1'b0, 8'hF0, 8'h22, 16'h0700, 16'h0000);
    chk("ea", ea, 16'h00F0);
    chk("len", 16'(len), 16'h0000);
    op(8'h00, 4'h5, 1'b0, 8'hFF, 8'h22, 16'h0700, 16'hFF00);
    chk("ea", ea, 16'h01FE);
    op(ceau_pkg::PRE_Y_SELECT, 4'h6, 1'b0, 8'h00, 8'h34, 16'h0710, 16'h1200);
    chk("ea", ea, 16'h1234);
    chk("use_y", 16'(use_y), 16'h0001);
    chk("len", 16'(len), 16'h0002);
    op(ceau_pkg::PRE_Y_SELECT, 4'h6, 1'b1, 8'h00, 8'h34, 16'h0710, 16'h1200);
    chk("illegal", 16'(illegal), 16'h0001);
    $display("t_indexed done");
  endtask : t_indexed
  // Pointer forms and relative target
  task automatic t_indirect();
    wr2(16'h0040, 16'h7700);
    op(ceau_pkg::PRE_IND_SELECT, 4'h2, 1'b0, 8'h11, 8'h22, 16'h0800, 16'h4000);
    chk("ea", ea, 16'h0077);
    wr2(16'h0050, 16'hABCD);
    op(ceau_pkg::PRE_IND_SELECT, 4'h3, 1'b0, 8'h11, 8'h22, 16'h0810, 16'h5000);
    chk("ea", ea, 16'hABCD);
    chk("len", 16'(len), 16'h0001);
    wr2(16'h0060, 16'hFF00);
    op(ceau_pkg::PRE_IND_SELECT, 4'h5, 1'b0, 8'hFF, 8'h22, 16'h0900, 16'h6000);
    chk("ea", ea, 16'h01FE);
    wr2(16'h0070, 16'h1000);
    op(ceau_pkg::PRE_IND_Y, 4'h6, 1'b0, 8'h00, 8'h34, 16'h0910, 16'h7000);
    chk("ea", ea, 16'h1034);
    op(8'h00, 4'h7, 1'b0, 8'h11, 8'h22, 16'h1000, 16'h8000);
    chk("ea", ea, 16'h0F80);
    $display("t_indirect done");
  endtask : t_indirect
  // Bit forms, memory-held branch offset, enable freeze, reset in mid-fetch
  task automatic t_control();
    op(8'h00, 4'h8, 1'b1, 8'h11, 8'h22, 16'h0A00, 16'h4C00);
    chk("ea", ea, 16'h004C);
    chk("illegal", 16'(illegal), 16'h0000);
    op(8'h00, 4'h9, 1'b1, 8'h11, 8'h22, 16'h0A10, 16'h5D7F);
    chk("ea", ea, 16'h005D);
    chk("len", 16'(len), 16'h0002);
    wr2(16'h0080, 16'hF000);
    op(ceau_pkg::PRE_IND_SELECT, 4'h7, 1'b0, 8'h11, 8'h22, 16'h0B00, 16'h8000);
    chk("ea", ea, 16'h0AF0);
    // Enable low in mid-fetch: the operand read waits and is not repeated
    wr2(16'h0C00, 16'h3900);
    @(posedge mclk) #1;
    {pv, mode, rmw, pc, start} = {1'b0, 4'h8, 1'b0, 16'h0C00, 1'b1};
    @(posedge mclk) #1;
    {start, ce} = 2'b00;
    repeat (3) @(posedge mclk) #1;
    chk("frozen", 16'(done), 16'h0000);
    chk("mem_addr", mem_addr, 16'h0C00);
    ce = 1'b1;
    repeat (2) @(posedge mclk) #1;
    chk("done", 16'(done), 16'h0001);
    chk("ea", ea, 16'h0039);
    // Reset during a long indirect fetch clears the sequencer and results
    @(posedge mclk) #1;
    {pre, pv, mode, start} = {ceau_pkg::PRE_IND_SELECT, 1'b1, 4'h3, 1'b1};
    @(posedge mclk) #1;
    {start, rst_b} = 2'b00;
    @(posedge mclk) #1;
    chk("rst_busy", 16'(busy), 16'h0000);
    chk("rst_ea", ea, 16'h0000);
    chk("rst_len", 16'(len), 16'h0000);
    rst_b = 1'b1;
    op(8'h00, 4'h2, 1'b0, 8'h11, 8'h22, 16'h0D00, 16'h6600);
    chk("ea", ea, 16'h0066);
    $display("t_control done");
  endtask : t_control
  // Watchdog: the run needs about 90 cycles, this allows 1000
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_direct();
    t_indexed();
    t_indirect();
    t_control();
    test_done();
  end
endmodule : ceau_unit_test
`default_nettype wire
